// >>> srq_pkg.sv
/*
 * Shared constants and types for the status reporting and service request block.
 * Assumes a single 250 MHz clock and an APB master with 32-bit data.
 */
package srq_pkg;

  // ****************************************************************
  // Bus and register map.
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] STATUS_BYTE_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] SERIAL_POLL_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] SRQ_ENABLE_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] STD_EVENT_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] STD_ENABLE_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] OPERATION_SUMMARY_BIT_EVENT_OFF = 8'h14;
  localparam logic [ADDR_W-1:0] OPERATION_SUMMARY_BIT_ENABLE_OFF = 8'h18;
  localparam logic [ADDR_W-1:0] TRIG_EVENT_OFF = 8'h1c;
  localparam logic [ADDR_W-1:0] RESPONSE_OFF = 8'h20;

  // ****************************************************************
  // Status byte bit positions.
  // ****************************************************************
  localparam int SB_TRIGGER_SEEN = 0;
  localparam int SB_ADVISORY = 2;
  localparam int SB_RESPONSE_WAITING = 4;
  localparam int SB_STD_SUMMARY = 5;
  localparam int SB_SERVICE = 6;
  localparam int SB_OPERATION = 7;

  // ****************************************************************
  // Standard event bit positions and reset value (power applied set).
  // ****************************************************************
  localparam int SE_DONE = 0;
  localparam int SE_CTRL_REQ = 1;
  localparam int SE_QUERY_ERR = 2;
  localparam int SE_DEV_ERR = 3;
  localparam int SE_EXEC_ERR = 4;
  localparam int SE_PARSE_ERR = 5;
  localparam int SE_FRONT_KEY = 6;
  localparam int SE_POWER = 7;
  localparam logic [7:0] STD_EVENT_RST = 8'h80;

  // ****************************************************************
  // Operation status register.
  // ****************************************************************
  localparam int OPERATION_SUMMARY_BIT_W = 16;
  localparam int OPERATION_SUMMARY_BIT_ARMED = 5;
  localparam int OPERATION_SUMMARY_BIT_OVERLOAD = 11;

  // Single-precision encoding of 9.9E+37, reported as infinity.
  localparam logic [DATA_W-1:0] INFINITY_CODE = 32'h7e94f56a;

  // Output queue geometry.
  localparam int OQ_DEPTH = 4;
  localparam int OQ_AW = 2;

  typedef enum logic [0:0] {
    EXEC_IDLE = 1'b0,
    EXEC_BUSY = 1'b1
  } exec_state_t;

  typedef struct packed {
    logic ctrl_req;
    logic query_err;
    logic dev_err;
    logic exec_err;
    logic parse_err;
  } parse_ev_t;

  typedef struct packed {
    logic front_key;
    logic trigger;
    logic armed;
    logic overload;
    logic advisory;
  } pins_t;

  typedef struct packed {
    logic failed;
    logic [DATA_W-1:0] value;
  } resp_t;

endpackage

// >>> output_queue.sv
/*
 * Output queue holding buffered query responses.
 * Assumes push, pop and flush come from logic on the same clock.
 */
`timescale 1ns/1ns
module output_queue (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill, drain and flush.
  input wire logic push_i,
  input wire logic [srq_pkg::DATA_W-1:0] data_i,
  input wire logic pop_i,
  input wire logic flush_i,
  // Head and occupancy.
  output logic [srq_pkg::DATA_W-1:0] data_o,
  output logic [srq_pkg::OQ_AW:0] count_o,
  output logic full_o,
  output logic empty_o
);

  logic [srq_pkg::DATA_W-1:0] mem_q [srq_pkg::OQ_DEPTH];
  logic [srq_pkg::OQ_AW-1:0] wr_q;
  logic [srq_pkg::OQ_AW-1:0] rd_q;
  logic [srq_pkg::OQ_AW:0] cnt_q;
  wire do_pop = pop_i & ~empty_o;
  // A pop in the same cycle frees a slot, so a push into a full queue is kept then.
  wire do_push = push_i & (~full_o | do_pop);

  assign full_o = (cnt_q == (srq_pkg::OQ_AW + 1)'(srq_pkg::OQ_DEPTH));
  assign empty_o = (cnt_q == '0);
  assign count_o = cnt_q;
  assign data_o = mem_q[rd_q];

  // Flush wins over a push in the same cycle so a cleared queue is truly empty.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || flush_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_push)
      begin
        mem_q[wr_q] <= data_i;
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (srq_pkg::OQ_AW + 1)'(do_push) - (srq_pkg::OQ_AW + 1)'(do_pop);
    end
  end

endmodule

// >>> status_srq.sv
/*
 * Status byte, event and enable registers, service request, output queue
 * control and sequential command gating, reached over APB.
 * Assumes parser strobes are on clk_i; front-panel and acquisition pins are not.
 */
`timescale 1ns/1ns

// Behaviour
// - queue summary bit follows queue non-empty
// - summary set by any enabled latched event
// - event bits latch until read or cleared
// - clear status empties event registers, not the output queue
// - clear after terminator also flushes output queue
// - standard events count only when enabled
// - enabled summary sets bit six
// - response buffered when query is parsed
// - commands run strictly one after another
// - infinity and failed measurement give 9.9E+37
// - parse and execution errors set events
// - device and query errors set events
// - power, front key, completion set events
// - response waiting bit tracks output queue
// - standard and operation summaries from enabled events
// - trigger latched, armed status while waiting
// - overload event and advisory bit
// - serial poll clears service request bit
// - status query leaves bit six alone
// - trigger event holds until read or cleared
module status_srq (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [srq_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [srq_pkg::DATA_W-1:0] pwdata_i,
  output logic [srq_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Parser and executor strobes.
  input wire srq_pkg::parse_ev_t parse_ev_i,
  input wire logic msg_terminator_i,
  input wire logic clear_status_i,
  input wire logic query_parsed_i,
  input wire srq_pkg::resp_t resp_i,
  input wire logic cmd_start_i,
  input wire logic cmd_done_i,
  output logic cmd_ready_o,
  output logic cmd_go_o,
  // Asynchronous instrument pins.
  input wire srq_pkg::pins_t pins_i,
  // Service request to the controller.
  output logic srq_o
);

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic any_enabled(input logic [srq_pkg::OPERATION_SUMMARY_BIT_W-1:0] ev,
                                       input logic [srq_pkg::OPERATION_SUMMARY_BIT_W-1:0] en);
    return |(ev & en);
  endfunction

  function automatic logic hit(input logic [srq_pkg::ADDR_W-1:0] a,
                               input logic [srq_pkg::ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ****************************************************************
  // Pin synchronisers and edge detection.
  // ****************************************************************
  srq_pkg::pins_t pin_m_q;
  srq_pkg::pins_t pin_s_q;
  logic key_prev_q;
  logic trig_prev_q;

  // Two flops per pin; edges are taken only from the second stage.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      key_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      pin_m_q <= pins_i;
      pin_s_q <= pin_m_q;
      key_prev_q <= pin_s_q.front_key;
      trig_prev_q <= pin_s_q.trigger;
    end
  end

  wire key_rise = pin_s_q.front_key & ~key_prev_q;
  wire trig_rise = pin_s_q.trigger & ~trig_prev_q;

  // ****************************************************************
  // APB decode.
  // ****************************************************************
  logic pready_q;
  logic pslverr_q;
  logic [srq_pkg::DATA_W-1:0] prdata_q;
  wire acc = psel_i & penable_i;
  wire capture = acc & ~pready_q;
  wire done = acc & pready_q;
  wire wr_done = done & pwrite_i;
  wire rd_done = done & ~pwrite_i;
  wire hit_stb = hit(paddr_i, srq_pkg::STATUS_BYTE_OFF);
  wire hit_poll = hit(paddr_i, srq_pkg::SERIAL_POLL_OFF);
  wire hit_sre = hit(paddr_i, srq_pkg::SRQ_ENABLE_OFF);
  wire hit_sesr = hit(paddr_i, srq_pkg::STD_EVENT_OFF);
  wire hit_ese = hit(paddr_i, srq_pkg::STD_ENABLE_OFF);
  wire hit_oev = hit(paddr_i, srq_pkg::OPERATION_SUMMARY_BIT_EVENT_OFF);
  wire hit_oen = hit(paddr_i, srq_pkg::OPERATION_SUMMARY_BIT_ENABLE_OFF);
  wire hit_trg = hit(paddr_i, srq_pkg::TRIG_EVENT_OFF);
  wire hit_resp = hit(paddr_i, srq_pkg::RESPONSE_OFF);
  wire mapped = hit_stb | hit_poll | hit_sre | hit_sesr | hit_ese | hit_oev | hit_oen
                | hit_trg | hit_resp;

  // ****************************************************************
  // Registers.
  // ****************************************************************
  logic [7:0] sre_q;
  logic [7:0] ese_q;
  logic [7:0] sesr_q;
  logic [7:0] sesr_cap_q;
  logic [srq_pkg::OPERATION_SUMMARY_BIT_W-1:0] oen_q;
  logic [srq_pkg::OPERATION_SUMMARY_BIT_W-1:0] oev_q;
  logic [srq_pkg::OPERATION_SUMMARY_BIT_W-1:0] oev_cap_q;
  logic trg_q;
  logic trg_cap_q;
  logic rqs_q;
  logic mss_q;
  logic term_q;
  srq_pkg::exec_state_t state_q;
  srq_pkg::exec_state_t state_d;
  logic cmd_ready_q;
  logic cmd_go_q;

  // Output queue wiring.
  logic [srq_pkg::DATA_W-1:0] oq_head;
  logic [srq_pkg::OQ_AW:0] oq_count;
  logic oq_full;
  logic oq_empty;
  wire oq_pop = rd_done & hit_resp & ~oq_empty;
  wire oq_underflow = rd_done & hit_resp & oq_empty;
  wire oq_overflow = query_parsed_i & oq_full & ~oq_pop;
  wire oq_flush = clear_status_i & term_q;
  // A failed measurement is pushed as the infinity code.
  wire [srq_pkg::DATA_W-1:0] oq_in = resp_i.failed ? srq_pkg::INFINITY_CODE
                                                    : resp_i.value;

  // The response is stored the cycle the parser reports the query.
  output_queue u_oq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .push_i(query_parsed_i),
    .data_i(oq_in),
    .pop_i(oq_pop),
    .flush_i(oq_flush),
    .data_o(oq_head),
    .count_o(oq_count),
    .full_o(oq_full),
    .empty_o(oq_empty)
  );

  // ****************************************************************
  // Event setting and summaries.
  // ****************************************************************
  wire opc_evt = (state_q == srq_pkg::EXEC_BUSY) & cmd_done_i;
  logic [7:0] sesr_set;
  logic [srq_pkg::OPERATION_SUMMARY_BIT_W-1:0] oev_set;
  logic [7:0] sb_low;

  // Event sources; overflow and empty reads count as query protocol errors.
  always_comb
  begin
    sesr_set = '0;
    sesr_set[srq_pkg::SE_PARSE_ERR] = parse_ev_i.parse_err;
    sesr_set[srq_pkg::SE_EXEC_ERR] = parse_ev_i.exec_err;
    sesr_set[srq_pkg::SE_DEV_ERR] = parse_ev_i.dev_err;
    sesr_set[srq_pkg::SE_QUERY_ERR] = parse_ev_i.query_err | oq_overflow
                                      | oq_underflow;
    sesr_set[srq_pkg::SE_CTRL_REQ] = parse_ev_i.ctrl_req;
    sesr_set[srq_pkg::SE_FRONT_KEY] = key_rise;
    sesr_set[srq_pkg::SE_DONE] = opc_evt;
    oev_set = '0;
    oev_set[srq_pkg::OPERATION_SUMMARY_BIT_ARMED] = pin_s_q.armed;
    oev_set[srq_pkg::OPERATION_SUMMARY_BIT_OVERLOAD] = pin_s_q.overload;
  end

  // Summaries are live: they follow their sources every cycle.
  wire std_sum = any_enabled(srq_pkg::OPERATION_SUMMARY_BIT_W'(sesr_q), srq_pkg::OPERATION_SUMMARY_BIT_W'(ese_q));
  wire operation_summary_bit_sum = any_enabled(oev_q, oen_q);

  always_comb
  begin
    sb_low = '0;
    sb_low[srq_pkg::SB_TRIGGER_SEEN] = trg_q;
    sb_low[srq_pkg::SB_ADVISORY] = pin_s_q.advisory;
    sb_low[srq_pkg::SB_RESPONSE_WAITING] = ~oq_empty;
    sb_low[srq_pkg::SB_STD_SUMMARY] = std_sum;
    sb_low[srq_pkg::SB_OPERATION] = operation_summary_bit_sum;
  end

  // Bit six of the enable register is ignored, so it never feeds itself.
  wire master_summary_bit = any_enabled(srq_pkg::OPERATION_SUMMARY_BIT_W'(sb_low), srq_pkg::OPERATION_SUMMARY_BIT_W'(sre_q));
  wire mss_rise = master_summary_bit & ~mss_q;
  wire [7:0] stb_val = sb_low | (8'(master_summary_bit) << srq_pkg::SB_SERVICE);
  wire [7:0] poll_val = sb_low | (8'(rqs_q) << srq_pkg::SB_SERVICE);

  // Clear-on-read removes only the bits that the read returned.
  wire sesr_rd = rd_done & hit_sesr;
  wire oev_rd = rd_done & hit_oev;
  wire trg_rd = rd_done & hit_trg;
  wire [7:0] sesr_d = (clear_status_i ? 8'h00 : (sesr_rd ? sesr_q & ~sesr_cap_q : sesr_q))
                      | sesr_set;
  wire [srq_pkg::OPERATION_SUMMARY_BIT_W-1:0] oev_d = (clear_status_i ? '0
                                      : (oev_rd ? oev_q & ~oev_cap_q : oev_q)) | oev_set;
  wire trg_d = (~clear_status_i & ~(trg_rd & trg_cap_q) & trg_q) | trig_rise;
  // A new rising summary raises the request even if a poll clears it now.
  wire rqs_d = mss_rise | (rqs_q & master_summary_bit & ~(rd_done & hit_poll));

  // ****************************************************************
  // Read data selection.
  // ****************************************************************
  wire [srq_pkg::DATA_W-1:0] rd_data =
    hit_stb ? srq_pkg::DATA_W'(stb_val) :
    hit_poll ? srq_pkg::DATA_W'(poll_val) :
    hit_sre ? srq_pkg::DATA_W'(sre_q) :
    hit_sesr ? srq_pkg::DATA_W'(sesr_q) :
    hit_ese ? srq_pkg::DATA_W'(ese_q) :
    hit_oev ? srq_pkg::DATA_W'(oev_q) :
    hit_oen ? srq_pkg::DATA_W'(oen_q) :
    hit_trg ? srq_pkg::DATA_W'(trg_q) :
    hit_resp ? (oq_empty ? '0 : oq_head) : '0;

  // One wait state: data is sampled, then the access completes.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      sesr_cap_q <= '0;
      oev_cap_q <= '0;
      trg_cap_q <= 1'b0;
    end
    else
    begin
      pready_q <= capture;
      if (capture)
      begin
        prdata_q <= rd_data;
        pslverr_q <= ~mapped;
        sesr_cap_q <= sesr_q;
        oev_cap_q <= oev_q;
        trg_cap_q <= trg_q;
      end
    end
  end

  // Enable registers; the controller must set them to get any request.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sre_q <= '0;
      ese_q <= '0;
      oen_q <= '0;
    end
    else
    begin
      if (wr_done & hit_sre)
        sre_q <= pwdata_i[7:0] & ~(8'h01 << srq_pkg::SB_SERVICE);
      if (wr_done & hit_ese)
        ese_q <= pwdata_i[7:0];
      if (wr_done & hit_oen)
        oen_q <= pwdata_i[srq_pkg::OPERATION_SUMMARY_BIT_W-1:0];
    end
  end

  // Event latches, request state and the terminator flag.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sesr_q <= srq_pkg::STD_EVENT_RST;
      oev_q <= '0;
      trg_q <= 1'b0;
      rqs_q <= 1'b0;
      mss_q <= 1'b0;
      term_q <= 1'b0;
    end
    else
    begin
      sesr_q <= sesr_d;
      oev_q <= oev_d;
      trg_q <= trg_d;
      rqs_q <= rqs_d;
      mss_q <= master_summary_bit;
      term_q <= msg_terminator_i | (term_q & ~cmd_start_i & ~query_parsed_i
                                    & ~clear_status_i);
    end
  end

  // ****************************************************************
  // Sequential command execution.
  // ****************************************************************
  always_comb
  begin
    case (state_q)
      srq_pkg::EXEC_IDLE: state_d = cmd_start_i ? srq_pkg::EXEC_BUSY : srq_pkg::EXEC_IDLE;
      srq_pkg::EXEC_BUSY: state_d = cmd_done_i ? srq_pkg::EXEC_IDLE : srq_pkg::EXEC_BUSY;
      default: state_d = srq_pkg::EXEC_IDLE;
    endcase
  end

  // A start while busy is ignored; the parser waits for cmd_ready_o.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= srq_pkg::EXEC_IDLE;
      cmd_ready_q <= 1'b0;
      cmd_go_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cmd_ready_q <= (state_d == srq_pkg::EXEC_IDLE);
      cmd_go_q <= (state_q == srq_pkg::EXEC_IDLE) & cmd_start_i;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign cmd_ready_o = cmd_ready_q;
  assign cmd_go_o = cmd_go_q;
  assign srq_o = rqs_q;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_mav;
    stb_val[srq_pkg::SB_RESPONSE_WAITING] == (oq_count != '0);
  endproperty
  a_mav: assert property (p_mav) else $error("response bit disagrees with queue");

  property p_std_sum;
    std_sum == |(sesr_q & ese_q);
  endproperty
  a_std_sum: assert property (p_std_sum) else $error("standard summary wrong");

  property p_latch;
    !clear_status_i && !sesr_rd |=> (($past(sesr_q) & ~sesr_q) == 8'h00);
  endproperty
  a_latch: assert property (p_latch) else $error("event bit lost");

  property p_cls;
    clear_status_i && !trig_rise |=> !trg_q && (oev_q == $past(oev_set));
  endproperty
  a_cls: assert property (p_cls) else $error("clear status left events");

  property p_flush;
    clear_status_i && term_q |=> oq_empty;
  endproperty
  a_flush: assert property (p_flush) else $error("output queue not flushed");

  property p_rqs;
    mss_rise |=> srq_o ##0 stb_val[srq_pkg::SB_SERVICE];
  endproperty
  a_rqs: assert property (p_rqs) else $error("service request not raised");

  property p_poll;
    rd_done && hit_poll && !mss_rise |=> !srq_o;
  endproperty
  a_poll: assert property (p_poll) else $error("serial poll did not clear request");

  property p_stb_keep;
    rd_done && hit_stb && rqs_q && master_summary_bit |=> srq_o;
  endproperty
  a_stb_keep: assert property (p_stb_keep) else $error("status query cleared request");

  property p_seq;
    state_q == srq_pkg::EXEC_BUSY && !cmd_done_i |=> !cmd_go_o [*2];
  endproperty
  a_seq: assert property (p_seq) else $error("command started while busy");

  property p_opc;
    opc_evt |=> sesr_q[srq_pkg::SE_DONE] && cmd_ready_o;
  endproperty
  a_opc: assert property (p_opc) else $error("completion event missing");

  property p_drop;
    !master_summary_bit |=> !srq_o;
  endproperty
  a_drop: assert property (p_drop) else $error("request held without summary");

  c_srq: cover property (mss_rise ##[1:20] (rd_done && hit_poll));
  c_flush: cover property (oq_flush && !oq_empty);
  c_seq: cover property (cmd_go_o ##[1:20] opc_evt);

endmodule

// >>> apb_ctrl.sv
/*
 * Controller model: an APB master that issues one register transfer per call.
 * Assumes the slave shares clk_i and answers with a pready pulse.
 */
`timescale 1ns/1ns
module apb_ctrl (
  // Clock.
  input wire logic clk_i,
  // APB master side.
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [srq_pkg::ADDR_W-1:0] paddr_o,
  output logic [srq_pkg::DATA_W-1:0] pwdata_o,
  input wire logic [srq_pkg::DATA_W-1:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  // Idle bus at time zero.
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end

  // Setup, then access held until pready is sampled; write data is inverted
  // after release so that a slave latching late sees a wrong value.
  // The wait has no limit of its own: the bench's timeout ends a hang.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
    end
    while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~d;
  endtask
endmodule

// >>> tb_status_srq.sv
/*
 * Self-checking bench for the status and service request block.
 * Assumes apb_ctrl as register master and srq_pkg for the map.
 */
`timescale 1ns/1ns
module tb_status_srq;
  logic clk_i;
  logic rst_n_i;
  logic [4:0] stb;
  srq_pkg::parse_ev_t pev;
  srq_pkg::pins_t pins;
  srq_pkg::resp_t resp;
  logic psel, penable, pwrite, pready, pslverr, cmd_ready, cmd_go, srq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic e;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] oq[$];
  // Strobe indices within stb.
  localparam int START = 0, DONE = 1, TERM = 2, CLR = 3, QRY = 4;

  apb_ctrl u_apb_ctrl (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));
  status_srq u_status_srq (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .parse_ev_i(pev),
    .msg_terminator_i(stb[TERM]), .clear_status_i(stb[CLR]), .query_parsed_i(stb[QRY]),
    .resp_i(resp), .cmd_start_i(stb[START]), .cmd_done_i(stb[DONE]),
    .cmd_ready_o(cmd_ready), .cmd_go_o(cmd_go), .pins_i(pins), .srq_o(srq));

  // The 4 ns clock.
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // A hang is cut short well beyond the expected few hundred cycles.
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register read compared with the model; the error flag must stay low.
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_apb_ctrl.xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_apb_ctrl.xfer(1'b1, a, d, r, e);
  endtask

  // One-cycle strobes; each starts on a fresh edge to avoid double assignment.
  task automatic pulse(input int k);
    @(posedge clk_i);
    stb <= 5'(1 << k);
    @(posedge clk_i);
    stb <= '0;
  endtask

  task automatic ev(input logic [4:0] b);
    @(posedge clk_i);
    pev <= b;
    @(posedge clk_i);
    pev <= '0;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    rst_n_i = 1'b0;
    stb = '0;
    pev = '0;
    pins = '0;
    resp = '0;
    void'($urandom(11745));
    wait_n(6);
    rst_n_i <= 1'b1;
    // Power-up state, read-clear and an unmapped access.
    rdc(srq_pkg::STD_EVENT_OFF, 32'h80);
    rdc(srq_pkg::STD_EVENT_OFF, 32'h0);
    rdc(srq_pkg::SRQ_ENABLE_OFF, 32'h0);
    u_apb_ctrl.xfer(1'b0, 8'h40, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    // A start while busy is ignored; completion sets the done event.
    // Outputs are looked at one edge after the strobe is taken, once settled.
    pulse(START);
    wait_n(1);
    chk({31'h0, cmd_go}, 32'h1);
    chk({31'h0, cmd_ready}, 32'h0);
    pulse(START);
    wait_n(1);
    chk({31'h0, cmd_go}, 32'h0);
    pulse(DONE);
    wait_n(1);
    chk({31'h0, cmd_ready}, 32'h1);
    rdc(srq_pkg::STD_EVENT_OFF, 32'h1);
    $display("test commands done");
    // Every parser event lands on its own bit.
    for (int i = 0; i < 5; i++)
    begin
      ev(5'(1 << i));
      rdc(srq_pkg::STD_EVENT_OFF, 32'(1 << (5 - i)));
    end
    $display("test parser events done");
    // Responses buffered at parse time; a failed one reads as infinity.
    for (int k = 0; k < 2; k++)
    begin
      v = $urandom;
      resp <= {k == 1, v};
      oq.push_back(k == 1 ? srq_pkg::INFINITY_CODE : v);
      pulse(QRY);
    end
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h10);
    pulse(CLR);
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h10);
    while (oq.size() > 0)
      rdc(srq_pkg::RESPONSE_OFF, oq.pop_front());
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h0);
    pulse(QRY);
    pulse(TERM);
    pulse(CLR);
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h0);
    $display("test output queue done");
    // Only enabled events reach the summary and the request.
    wr(srq_pkg::STD_ENABLE_OFF, 32'h1 << srq_pkg::SE_EXEC_ERR);
    wr(srq_pkg::SRQ_ENABLE_OFF, 32'h1 << srq_pkg::SB_STD_SUMMARY);
    ev(5'h01);
    wait_n(4);
    chk({31'h0, srq}, 32'h0);
    ev(5'h02);
    wait_n(4);
    chk({31'h0, srq}, 32'h1);
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h60);
    chk({31'h0, srq}, 32'h1);
    rdc(srq_pkg::SERIAL_POLL_OFF, 32'h60);
    wait_n(1);
    chk({31'h0, srq}, 32'h0);
    pulse(CLR);
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h0);
    ev(5'h02);
    wait_n(4);
    chk({31'h0, srq}, 32'h1);
    wr(srq_pkg::STD_ENABLE_OFF, 32'h0);
    wait_n(3);
    chk({31'h0, srq}, 32'h0);
    pulse(CLR);
    $display("test service request done");
    // Pin events pass through the synchronisers before they latch.
    pins.trigger <= 1'b1;
    pins.front_key <= 1'b1;
    wait_n(6);
    pins <= '0;
    wait_n(6);
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h1);
    rdc(srq_pkg::TRIG_EVENT_OFF, 32'h1);
    rdc(srq_pkg::TRIG_EVENT_OFF, 32'h0);
    rdc(srq_pkg::STD_EVENT_OFF, 32'h40);
    pins.armed <= 1'b1;
    pins.overload <= 1'b1;
    pins.advisory <= 1'b1;
    wait_n(6);
    rdc(srq_pkg::OPERATION_SUMMARY_BIT_EVENT_OFF, 32'h820);
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h4);
    $display("test pins done");
    // Enabled operation event reaches bit seven; an empty response read is a query error.
    wr(srq_pkg::OPERATION_SUMMARY_BIT_ENABLE_OFF, 32'h1 << srq_pkg::OPERATION_SUMMARY_BIT_OVERLOAD);
    rdc(srq_pkg::STATUS_BYTE_OFF, 32'h84);
    rdc(srq_pkg::RESPONSE_OFF, 32'h0);
    rdc(srq_pkg::STD_EVENT_OFF, 32'h4);
    $display("test summaries done");
    results();
  end
endmodule
